// ### design/mil_edge_det.sv
`include "mil_regs.svh"
`default_nettype none
module mil_edge_det
  import mil_pkg::*;
(
  input  wire logic       i_clk,
  input  wire logic       i_rst_n,
  input  wire logic       i_ce,
  input  wire logic       i_rising,
  input  wire logic       i_pin,
  input  wire logic [3:0] i_port_hi,
  input  wire logic       i_port_rd,
  output logic            o_ext_edge,
  output logic            o_port_chg
);
  logic       pin_q;
  logic [3:0] latch_q;
  logic       primed;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pin_q   <= 1'b0;
      latch_q <= 4'h0;
      primed  <= 1'b0;
    end else if (i_ce) begin
      pin_q  <= i_pin;
      primed <= 1'b1;
      if (i_port_rd) begin
        latch_q <= i_port_hi;
      end
    end
  end

  // selected edge of the external pin
  assign o_ext_edge = primed && i_ce &&
                      (i_rising ? (i_pin && !pin_q) : (!i_pin && pin_q));

  // mismatch with last read value; a change during the read is absorbed
  assign o_port_chg = primed && i_ce && !i_port_rd &&
                      (i_port_hi != latch_q);
endmodule
`default_nettype wire

// ### design/mil_entry_seq.sv
`include "mil_regs.svh"
`default_nettype none
module mil_entry_seq
  import mil_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  input  wire logic        i_ce,
  input  wire logic        i_req,
  input  wire logic        i_block,
  output logic             o_take,
  output logic             o_nop,
  output mil_state_t       o_state
);
  mil_state_t state;
  mil_state_t next_state;

  always_comb begin
    next_state = state;
    case (state)
      MIL_RUN: begin
        if (i_req && !i_block) begin
          next_state = MIL_SYNC;
        end
      end
      MIL_SYNC: begin
        next_state = i_req ? MIL_ENTER : MIL_RUN;
      end
      MIL_ENTER: begin
        next_state = MIL_RUN;
      end
      default: begin
        next_state = MIL_RUN;
      end
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state <= MIL_RUN;
    end else if (i_ce) begin
      state <= next_state;
    end
  end

  assign o_take  = i_ce && (state == MIL_ENTER);
  assign o_nop   = i_ce && (state == MIL_RUN) && i_req && i_block;
  assign o_state = state;
endmodule
`default_nettype wire

// ### design/mil_irq_logic.sv
// Summary of operation
// - four sources: external pin edge, timer overflow, port change, comparator.
// - control bit 7 global enable passes unmasked requests, blocks all when clear.
// - any reset clears the global enable.
// - return-from-interrupt pops the return address and sets global enable.
// - on entry clear global enable, push return address, load vector 0004h.
// - pin or port events reach the vector in three cycles.
// - flags set on their event regardless of any enable bit.
// - clearing global enable suppresses next-cycle interrupt, runs a no-op.
// - external pin edge selected by option bit 6, set means rising.
// - pin edge sets control bit 1; control bit 4 enables it.
// - enabled pin interrupt wakes from sleep; global enable decides branching.
// - timer rollover sets control bit 2; control bit 5 enables it.
// - port pins 7..4 change sets control bit 0; its enable is bit 3.
// - a pin change during a port read may not set the flag.
// - comparator flag and enable live in separate peripheral registers.
// - only the return address is pushed, no working or status save.
// - enabled set flag wakes from sleep even with global enable clear.
`include "mil_regs.svh"
`default_nettype none
module mil_irq_logic
  import mil_pkg::*;
(
  input  wire logic                   i_clk,
  input  wire logic                   i_rst_n,
  input  wire logic                   i_ce,
  input  wire logic [`MIL_ADDR_W-1:0] i_addr,
  input  wire logic [7:0]             i_wdata,
  input  wire logic                   i_wr,
  input  wire logic                   i_rd,
  output logic      [7:0]             o_rdata,
  input  wire logic                   i_ext_irq_pin,
  input  wire logic [3:0]             i_port_hi,
  input  wire logic                   i_port_rd,
  input  wire logic                   i_timer_ovf,
  input  wire logic                   i_cmp_evt,
  input  wire logic                   i_return_from_irq_instr,
  input  wire logic                   i_gie_clr_instr,
  input  wire logic [12:0]            i_pc_next,
  input  wire logic                   i_sleeping,
  output logic                        o_irq_req,
  output logic                        o_take,
  output logic                        o_force_nop,
  output logic                        o_pc_load,
  output logic      [12:0]            o_pc_value,
  output logic                        o_push,
  output logic      [12:0]            o_push_data,
  output logic                        o_pop,
  output logic                        o_wake,
  output logic                        o_irq
);
  logic [7:0] ctrl;
  logic [7:0] option;
  logic       cmp_flag;
  logic       cmp_en;
  logic [3:0] istat;
  logic [3:0] imask;
  logic       gie_blk;
  logic       ext_edge;
  logic       port_chg;
  logic       take;
  logic       nop;
  mil_state_t seq_state;
  mil_src_t   flags;
  mil_src_t   ens;
  mil_src_t   evt;
  mil_src_t   pend;

  function automatic logic wr_at(input logic [`MIL_ADDR_W-1:0] idx);
    wr_at = i_ce && i_wr && (i_addr == idx);
  endfunction

  mil_edge_det u_edge (
    .i_clk      (i_clk),
    .i_rst_n    (i_rst_n),
    .i_ce       (i_ce),
    .i_rising   (option[`MIL_BIT_EDGE]),
    .i_pin      (i_ext_irq_pin),
    .i_port_hi  (i_port_hi),
    .i_port_rd  (i_port_rd),
    .o_ext_edge (ext_edge),
    .o_port_chg (port_chg)
  );

  // four event sources
  assign evt.ext = ext_edge;
  assign evt.tmr = i_ce && i_timer_ovf;
  assign evt.pch = port_chg;
  assign evt.cmp = i_ce && i_cmp_evt;

  assign flags.ext = ctrl[`MIL_BIT_EXT_FLAG];
  assign flags.tmr = ctrl[`MIL_BIT_TMR_FLAG];
  assign flags.pch = ctrl[`MIL_BIT_PCH_FLAG];
  assign flags.cmp = cmp_flag;
  assign ens.ext   = ctrl[`MIL_BIT_EXT_EN];
  assign ens.tmr   = ctrl[`MIL_BIT_TMR_EN];
  assign ens.pch   = ctrl[`MIL_BIT_PCH_EN];
  assign ens.cmp   = cmp_en;

  assign pend = flags & ens;
  assign o_irq_req = (|pend) && ctrl[`MIL_BIT_GIE];

  // global enable, enables and core-owned flags
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ctrl <= `MIL_CTRL_RST;
    end else if (i_ce) begin
      if (wr_at(`MIL_IDX_CTRL)) begin
        ctrl <= i_wdata;
      end
      if (i_gie_clr_instr || take) begin
        ctrl[`MIL_BIT_GIE] <= 1'b0;
      end else if (i_return_from_irq_instr) begin
        ctrl[`MIL_BIT_GIE] <= 1'b1;
      end
      // set wins over software clear, enables ignored
      if (evt.ext) begin
        ctrl[`MIL_BIT_EXT_FLAG] <= 1'b1;
      end
      if (evt.tmr) begin
        ctrl[`MIL_BIT_TMR_FLAG] <= 1'b1;
      end
      if (evt.pch) begin
        ctrl[`MIL_BIT_PCH_FLAG] <= 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      option <= `MIL_OPTION_RST;
    end else if (wr_at(`MIL_IDX_OPTION)) begin
      option <= i_wdata;
    end
  end

  // peripheral flag and enable registers
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cmp_flag <= 1'b0;
      cmp_en   <= 1'b0;
    end else if (i_ce) begin
      if (wr_at(`MIL_IDX_PFLAG)) begin
        cmp_flag <= i_wdata[`MIL_BIT_CMP];
      end
      if (evt.cmp) begin
        cmp_flag <= 1'b1;
      end
      if (wr_at(`MIL_IDX_PEN)) begin
        cmp_en <= i_wdata[`MIL_BIT_CMP];
      end
    end
  end

  // clear of global enable blocks the next cycle's entry
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      gie_blk <= 1'b0;
    end else if (i_ce) begin
      gie_blk <= i_gie_clr_instr;
    end
  end

  mil_entry_seq u_seq (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_ce    (i_ce),
    .i_req   (o_irq_req && !i_gie_clr_instr),
    .i_block (gie_blk || i_sleeping),
    .o_take  (take),
    .o_nop   (nop),
    .o_state (seq_state)
  );

  // entry: push return address only, vector load; fixed pipeline length
  assign o_take      = take;
  assign o_pc_load   = take;
  assign o_pc_value  = `MIL_VECTOR;
  assign o_push      = take;
  assign o_push_data = i_pc_next;
  assign o_pop       = i_ce && i_return_from_irq_instr;
  // pending request ignored in the cycle after a global enable clear
  assign o_force_nop = nop || (i_ce && seq_state == MIL_SYNC) ||
                       (i_ce && gie_blk && (|pend));

  // wake regardless of global enable
  assign o_wake = i_sleeping && (|pend);

  // event status, write one to clear, set wins
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      istat <= 4'h0;
      imask <= 4'h0;
    end else if (i_ce) begin
      if (wr_at(`MIL_IDX_ISTAT)) begin
        istat <= (istat & ~i_wdata[3:0]) | evt;
      end else begin
        istat <= istat | evt;
      end
      if (wr_at(`MIL_IDX_IMASK)) begin
        imask <= i_wdata[3:0];
      end
    end
  end

  assign o_irq = |(istat & imask);

  // read port
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rdata <= 8'h00;
    end else if (i_ce) begin
      o_rdata <= 8'h00;
      if (i_rd) begin
        case (i_addr)
          `MIL_IDX_CTRL:   o_rdata <= ctrl;
          `MIL_IDX_OPTION: o_rdata <= option;
          `MIL_IDX_PFLAG:  o_rdata <= {7'h00, cmp_flag};
          `MIL_IDX_PEN:    o_rdata <= {7'h00, cmp_en};
          `MIL_IDX_ISTAT:  o_rdata <= {4'h0, istat};
          `MIL_IDX_IMASK:  o_rdata <= {4'h0, imask};
          `MIL_IDX_PORT:   o_rdata <= {6'h00, seq_state};
          default:         o_rdata <= 8'h00;
        endcase
      end
    end
  end

  a_gie_reenable: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_ce && i_return_from_irq_instr && !i_gie_clr_instr && !take
    |=> ctrl[`MIL_BIT_GIE]) else $error("gie not set by return");
  a_entry_clears_gie: assert property (@(posedge i_clk)
    disable iff (!i_rst_n)
    take |=> !ctrl[`MIL_BIT_GIE]) else $error("gie kept on entry");
  a_entry_latency: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    seq_state == MIL_SYNC && o_irq_req && i_ce && !i_gie_clr_instr
    |=> take)
    else $error("entry late");
  a_no_entry_off: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    take |-> $past(o_irq_req, 2)) else $error("entry without request");
  a_flag_sticks: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    evt.tmr |=> ctrl[`MIL_BIT_TMR_FLAG]) else $error("timer flag lost");
  a_ext_flag: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    evt.ext |=> ctrl[`MIL_BIT_EXT_FLAG]) else $error("ext flag lost");
  a_pch_flag: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    evt.pch |=> ctrl[`MIL_BIT_PCH_FLAG]) else $error("port flag lost");
  a_cmp_flag: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    evt.cmp |=> cmp_flag) else $error("cmp flag lost");
  a_nop_block: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_ce && i_gie_clr_instr |=> !take) else $error("entry after clear");
  a_wake_pend: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_sleeping && (|pend) |-> o_wake) else $error("no wake");
  a_req_form: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    o_irq_req |-> ctrl[`MIL_BIT_GIE] && (|pend)) else $error("bad req");

  c_entry: cover property (@(posedge i_clk) disable iff (!i_rst_n) take);
  c_nop: cover property (@(posedge i_clk) disable iff (!i_rst_n) nop);
  c_wake: cover property (@(posedge i_clk) disable iff (!i_rst_n) o_wake);
endmodule
`default_nettype wire

// ### design/mil_pkg.sv
`default_nettype none
package mil_pkg;
  typedef enum logic [1:0] {
    MIL_RUN   = 2'b00,
    MIL_SYNC  = 2'b01,
    MIL_ENTER = 2'b10
  } mil_state_t;

  typedef struct packed {
    logic       global_irq_enable;
    logic       ext_en;
    logic       tmr_en;
    logic       pch_en;
    logic       cmp_en;
  } mil_en_t;

  typedef struct packed {
    logic       ext;
    logic       tmr;
    logic       pch;
    logic       cmp;
  } mil_src_t;
endpackage
`default_nettype wire

// ### design/mil_regs.svh
`ifndef MIL_REGS_SVH
`define MIL_REGS_SVH
// register indices (address = index, matched directly against i_addr)
`define MIL_ADDR_W          8
`define MIL_IDX_CTRL        8'h0b
`define MIL_IDX_PFLAG       8'h0c
`define MIL_IDX_OPTION      8'h81
`define MIL_IDX_PEN         8'h8c
`define MIL_IDX_ISTAT       8'hf0
`define MIL_IDX_IMASK       8'hf1
`define MIL_IDX_PORT        8'hf2
// control, option and peripheral register fields
`define MIL_BIT_GIE         7
`define MIL_BIT_TMR_EN      5
`define MIL_BIT_EXT_EN      4
`define MIL_BIT_PCH_EN      3
`define MIL_BIT_TMR_FLAG    2
`define MIL_BIT_EXT_FLAG    1
`define MIL_BIT_PCH_FLAG    0
`define MIL_BIT_EDGE        6
`define MIL_BIT_CMP         0
// reset values and entry vector
`define MIL_CTRL_RST        8'h00
`define MIL_OPTION_RST      8'hff
`define MIL_VECTOR          13'h0004
// entry takes this many cycles from request sample to vector load
`define MIL_ENTRY_CYC       2'h2
`endif

// ### verification/mil_core_model.sv
`default_nettype none
module mil_core_model (
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  input  wire logic        i_pc_load,
  input  wire logic [12:0] i_pc_value,
  input  wire logic        i_push,
  input  wire logic [12:0] i_push_data,
  input  wire logic        i_pop,
  output logic      [12:0] o_pc_next,
  output logic      [3:0]  o_depth
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [12:0] pc;
  logic [12:0] stack [8];
  // core side: program counter and eight-deep return stack
  assign o_pc_next = pc + 13'h0001;
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pc      <= 13'h0000;
      o_depth <= 4'h0;
    end else if (i_pc_load) begin
      pc                  <= i_pc_value;
      stack[o_depth[2:0]] <= i_push_data;
      o_depth             <= o_depth + {3'h0, i_push};
    end else if (i_pop && o_depth != 4'h0) begin
      pc      <= stack[o_depth[2:0] - 3'h1];
      o_depth <= o_depth - 4'h1;
    end else begin
      pc <= o_pc_next;
    end
  end
endmodule
`default_nettype wire

// ### verification/tb.sv
`default_nettype none
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin errors++; \
  $display("unexpected at %0t: got %h want %h", $time, g, e); end end
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        i_clk, i_rst_n, i_wr, i_rd, i_pin, i_port_rd, i_tmr, i_cmp;
  logic        i_ret, i_gclr, i_sleeping, o_irq_req, o_take, o_force_nop;
  logic        o_pc_load, o_push, o_pop, o_wake, o_irq;
  logic [7:0]  i_addr, i_wdata, o_rdata, rd_val;
  logic [3:0]  i_port_hi, depth;
  logic [12:0] pc_next, o_pc_value, o_push_data;
  int          errors, samples_checked, n;
  mil_irq_logic i_dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_ce(1'b1),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
    .o_rdata(o_rdata), .i_ext_irq_pin(i_pin), .i_port_hi(i_port_hi),
    .i_port_rd(i_port_rd), .i_timer_ovf(i_tmr), .i_cmp_evt(i_cmp),
    .i_return_from_irq_instr(i_ret), .i_gie_clr_instr(i_gclr),
    .i_pc_next(pc_next), .i_sleeping(i_sleeping), .o_irq_req(o_irq_req),
    .o_take(o_take), .o_force_nop(o_force_nop), .o_pc_load(o_pc_load),
    .o_pc_value(o_pc_value), .o_push(o_push), .o_push_data(o_push_data),
    .o_pop(o_pop), .o_wake(o_wake), .o_irq(o_irq));
  mil_core_model i_core (.i_clk(i_clk), .i_rst_n(i_rst_n),
    .i_pc_load(o_pc_load), .i_pc_value(o_pc_value), .i_push(o_push),
    .i_push_data(o_push_data), .i_pop(o_pop), .o_pc_next(pc_next),
    .o_depth(depth));
  initial begin
    i_clk = 1'b0;
    forever #12.5 i_clk = ~i_clk;
  end
  task automatic complete_run();
    $display("checks %0d, mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge i_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_addr  <= a;
    i_wdata <= d;
    i_wr    <= 1'b1;
    @(posedge i_clk);
    i_wr    <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge i_clk);
    i_addr <= a;
    i_rd   <= 1'b1;
    @(posedge i_clk);
    i_rd   <= 1'b0;
    #1 rd_val = o_rdata;
  endtask
  // counts edges until the vector is taken
  task automatic wait_take();
    for (n = 1; n <= 12; n++) begin
      @(posedge i_clk);
      #1;
      if (o_take === 1'b1) return;
    end
    errors++;
    $display("unexpected at %0t: no vector entry", $time);
    complete_run();
  endtask
  task automatic done(input string s);
    $display("test %s done", s);
  endtask
  initial begin
    {i_wr, i_rd, i_pin, i_port_rd, i_tmr, i_cmp, i_ret, i_gclr} = '0;
    {i_addr, i_wdata, i_port_hi, i_sleeping, i_rst_n} = '0;
    errors = 0;
    samples_checked = 0;
    tick(5);
    i_rst_n <= 1'b1;
    rd(8'h0b); `CHK(rd_val, 8'h00)
    rd(8'h81); `CHK(rd_val, 8'hff)
    wr(8'h55, 8'hff);
    rd(8'h55); `CHK(rd_val, 8'h00)
    done("reset");
    @(posedge i_clk);
    i_tmr <= 1'b1;
    i_cmp <= 1'b1;
    @(posedge i_clk);
    {i_tmr, i_cmp} <= 2'b00;
    rd(8'h0b); `CHK(rd_val, 8'h04)
    rd(8'h0c); `CHK(rd_val, 8'h01)
    `CHK(o_irq_req, 1'b0)
    rd(8'hf0); `CHK(rd_val, 8'h05)
    `CHK(o_irq, 1'b0)
    wr(8'hf1, 8'h04); #1 `CHK(o_irq, 1'b1)
    wr(8'hf0, 8'h04); #1 `CHK(o_irq, 1'b0)
    rd(8'hf0); `CHK(rd_val, 8'h01)
    wr(8'hf0, 8'h01);
    wr(8'h0b, 8'h00);
    done("flags");
    @(posedge i_clk) i_pin <= 1'b1;
    tick(4);
    rd(8'h0b); `CHK(rd_val, 8'h02)
    wr(8'h0b, 8'h00);
    wr(8'h81, 8'hbf);
    @(posedge i_clk) i_pin <= 1'b0;
    tick(4);
    rd(8'h0b); `CHK(rd_val, 8'h02)
    wr(8'h0b, 8'h00);
    @(posedge i_clk) i_pin <= 1'b1;
    tick(4);
    rd(8'h0b); `CHK(rd_val, 8'h00)
    done("edge");
    @(posedge i_clk) i_port_rd <= 1'b1;
    @(posedge i_clk) i_port_rd <= 1'b0;
    i_port_hi <= 4'ha;
    tick(3);
    rd(8'h0b); `CHK(rd_val, 8'h01)
    @(posedge i_clk) i_port_rd <= 1'b1;
    @(posedge i_clk) i_port_rd <= 1'b0;
    wr(8'h0b, 8'h00);
    tick(3);
    rd(8'h0b); `CHK(rd_val, 8'h00)
    done("port");
    wr(8'h81, 8'hff);
    @(posedge i_clk) i_pin <= 1'b0;
    wr(8'h0b, 8'h90);
    @(posedge i_clk) i_pin <= 1'b1;
    wait_take();
    `CHK(n >= 3 && n <= 4, 1'b1)
    `CHK(o_pc_load, 1'b1)
    `CHK(o_pc_value, 13'h0004)
    `CHK({o_push, o_push_data}, {1'b1, pc_next})
    tick(2);
    `CHK(depth, 4'h1)
    rd(8'h0b); `CHK(rd_val, 8'h12)
    wr(8'h0b, 8'h10);
    @(posedge i_clk) i_ret <= 1'b1;
    #1 `CHK(o_pop, 1'b1)
    @(posedge i_clk) i_ret <= 1'b0;
    rd(8'h0b); `CHK(rd_val, 8'h90)
    `CHK(depth, 4'h0)
    done("entry");
    wr(8'h0b, 8'h20);
    @(posedge i_clk) i_tmr <= 1'b1;
    @(posedge i_clk) i_tmr <= 1'b0;
    tick(6);
    `CHK({o_irq_req, o_take}, 2'b00)
    @(posedge i_clk);
    i_addr  <= 8'h0b;
    i_wdata <= 8'ha4;
    i_wr    <= 1'b1;
    i_gclr  <= 1'b1;
    @(posedge i_clk);
    {i_wr, i_gclr} <= 2'b00;
    #1 `CHK({o_force_nop, o_take}, 2'b10)
    tick(3);
    `CHK({o_irq_req, o_take}, 2'b00)
    @(posedge i_clk) i_ret <= 1'b1;
    @(posedge i_clk) i_ret <= 1'b0;
    wait_take();
    `CHK(n >= 2, 1'b1)
    wr(8'h0b, 8'h20);
    @(posedge i_clk) i_ret <= 1'b1;
    @(posedge i_clk) i_ret <= 1'b0;
    done("nop");
    wr(8'h0b, 8'h12);
    i_sleeping <= 1'b1;
    tick(2);
    `CHK({o_wake, o_irq_req}, 2'b10)
    wr(8'h0b, 8'h02);
    #1 `CHK(o_wake, 1'b0)
    i_sleeping <= 1'b0;
    done("sleep");
    complete_run();
  end
endmodule
`default_nettype wire
